// ==== design/async_serial_consts.vh ====
// Purpose: Constants for the asynchronous serial interface
// Assumes: 32-bit AHB-Lite register words, byte addresses
// Notes: Definitions only
`ifndef ASYNC_SERIAL_CONSTS_VH
`define ASYNC_SERIAL_CONSTS_VH
`define ADDR_RATE_SEL 8'h00
`define ADDR_CTRL_ONE 8'h04
`define ADDR_CTRL_TWO 8'h08
`define ADDR_STATUS 8'h0c
`define ADDR_DATA 8'h10
`define C1_R8 0
`define C1_T8 1
`define C1_LEN9 2
`define C1_WAKE 3
`define C2_SBK 0
`define C2_RWU 1
`define C2_RE 2
`define C2_TE 3
`define C2_ILIE 4
`define C2_RIE 5
`define C2_TX_DONE_IRQ_EN 6
`define C2_TIE 7
`define ST_FE 1
`define ST_NF 2
`define ST_OR 3
`define ST_IDLE 4
`define ST_RX_BUF_FULL_FLAG 5
`define ST_TC 6
`define ST_TX_BUF_EMPTY_FLAG 7
`define PRE_0 11'h001
`define PRE_1 11'h003
`define PRE_2 11'h004
`define PRE_3 11'h00d
`define SAMPLES_PER_BIT 16
`define FRAME_BITS_8 4'ha
`define FRAME_BITS_9 4'hb
`define IDLE_TICKS_8 8'ha0
`define IDLE_TICKS_9 8'hb0
`define BREAK_DATA 8'h00
`endif

// ==== design/async_serial_interface.v ====
// Purpose: Full-duplex asynchronous serial interface with AHB-Lite registers
// Assumes: Single 50 MHz clock; rx pin is asynchronous and synchronised here
// Notes: Function
`timescale 1ns/1ps
`include "async_serial_consts.vh"
module async_serial_interface (
  input wire i_clock,
  input wire i_reset,
  input wire i_hsel,
  input wire [31:0] i_haddr,
  input wire [1:0] i_htrans,
  input wire i_hwrite,
  input wire [2:0] i_hsize,
  input wire [31:0] i_hwdata,
  input wire i_hready,
  output reg [31:0] o_hrdata,
  output wire o_hreadyout,
  output wire o_hresp,
  input wire i_rx_serial_in,
  output wire o_tx_serial_out,
  output wire o_tx_drive,
  output wire o_irq
);
  localparam TX_IDLE = 3'b001;
  localparam TX_SEND = 3'b010;
  localparam TX_BRK = 3'b100;
  localparam RX_IDLE = 2'b01;
  localparam RX_FRAME = 2'b10;

  reg [4:0] rate_sel_r;
  reg [3:0] ctrl_one_r;
  reg [7:0] ctrl_two_r;
  reg tx_buf_empty_flag_r, tc_r, rx_buf_full_flag_r, idle_r, or_r, nf_r, fe_r;
  reg [6:0] seen_r;
  reg [7:0] tx_buf_r;
  reg tx_pend_r;
  reg [7:0] rx_data_r;
  reg wr_pend_r;
  reg [7:0] wr_addr_r;
  wire len9 = ctrl_one_r[`C1_LEN9];
  wire [3:0] frame_bits = len9 ? `FRAME_BITS_9 : `FRAME_BITS_8;

  // Bus slave: always ready, always OKAY, reads answered from flops
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;
  wire addr_ok = i_hsel & i_htrans[1] & i_hready;
  wire rd_go = addr_ok & ~i_hwrite;
  wire [7:0] ra = i_haddr[7:0];
  wire rd_status = rd_go & (ra == `ADDR_STATUS);
  wire rd_data = rd_go & (ra == `ADDR_DATA);
  wire wr_data = wr_pend_r & (wr_addr_r == `ADDR_DATA);
  wire [7:0] status_now = {tx_buf_empty_flag_r, tc_r, rx_buf_full_flag_r, idle_r, or_r, nf_r, fe_r, 1'b0};
  reg [31:0] rd_val;
  always @* begin
    rd_val = 32'h0;
    if (ra == `ADDR_RATE_SEL) begin
      rd_val = {27'h0, rate_sel_r};
    end else if (ra == `ADDR_CTRL_ONE) begin
      rd_val = {28'h0, ctrl_one_r};
    end else if (ra == `ADDR_CTRL_TWO) begin
      rd_val = {24'h0, ctrl_two_r};
    end else if (ra == `ADDR_STATUS) begin
      rd_val = {24'h0, status_now};
    end else if (ra == `ADDR_DATA) begin
      rd_val = {24'h0, rx_data_r};
    end
  end

  // Rate divider: prescale times power of two gives 32 choices
  reg [10:0] div_r;
  reg [10:0] pre;
  always @* begin
    case (rate_sel_r[4:3])
      2'b00: pre = `PRE_0;
      2'b01: pre = `PRE_1;
      2'b10: pre = `PRE_2;
      default: pre = `PRE_3;
    endcase
  end
  wire [10:0] divisor = pre << rate_sel_r[2:0];
  wire tick = (div_r >= divisor - 11'h001);
  always @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      div_r <= 11'h000;
    end else begin
      div_r <= tick ? 11'h000 : div_r + 11'h001;
    end
  end

  // Receive pin synchroniser
  reg rx_s1_r, rx_s2_r;
  always @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      rx_s1_r <= 1'b1;
      rx_s2_r <= 1'b1;
    end else begin
      rx_s1_r <= i_rx_serial_in;
      rx_s2_r <= rx_s1_r;
    end
  end
  wire rxs = rx_s2_r;

  // Receiver
  reg [1:0] rx_st_r;
  reg [3:0] rt_r;
  reg [3:0] bit_r;
  reg [1:0] smp_r;
  reg [1:0] vlow_r;
  reg nz_r, armed_r, got_char_r, idle_done_r;
  reg [8:0] rsh_r;
  reg [7:0] idle_cnt_r;
  wire standby = ctrl_two_r[`C2_RWU];
  wire [7:0] idle_lim = len9 ? `IDLE_TICKS_9 : `IDLE_TICKS_8;
  wire vote = (smp_r[1] & smp_r[0]) | (smp_r[1] & rxs) | (smp_r[0] & rxs);
  wire odd = ~((smp_r[1] == smp_r[0]) & (smp_r[0] == rxs));
  wire last_bit = (bit_r == frame_bits - 4'h1);
  wire [8:0] rsh_in = {vote, rsh_r[8:1]};
  // In 8-bit mode bit 0 of the shifter is stale from the previous frame
  wire is_break = ~vote & (len9 ? (rsh_r == 9'h000) : (rsh_r[8:1] == 8'h00));
  wire fin = (rx_st_r == RX_FRAME) & tick & (rt_r == 4'h9) & last_bit;
  wire addr_mark = rsh_r[8];
  wire wake_addr = fin & standby & ctrl_one_r[`C1_WAKE] & addr_mark;
  wire accept = fin & (~standby | wake_addr);
  wire idle_hit = (rx_st_r == RX_IDLE) & tick & rxs & (idle_cnt_r == idle_lim - 8'h01);
  wire wake_idle = idle_hit & standby & ~ctrl_one_r[`C1_WAKE];
  wire set_rx_buf_full_flag = accept & ~rx_buf_full_flag_r;
  wire set_or = accept & rx_buf_full_flag_r;
  wire set_fe = accept & ~rx_buf_full_flag_r & ~vote;
  wire set_nf = accept & ~rx_buf_full_flag_r & (nz_r | odd);
  wire set_idle = idle_hit & ~standby & got_char_r;
  always @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      rx_st_r <= RX_IDLE;
      rt_r <= 4'h0;
      bit_r <= 4'h0;
      smp_r <= 2'b11;
      vlow_r <= 2'b00;
      nz_r <= 1'b0;
      armed_r <= 1'b0;
      got_char_r <= 1'b0;
      rsh_r <= 9'h000;
      idle_cnt_r <= 8'h00;
      rx_data_r <= 8'h00;
      idle_done_r <= 1'b0;
    end else if (~ctrl_two_r[`C2_RE]) begin
      rx_st_r <= RX_IDLE;
      armed_r <= 1'b0;
      idle_cnt_r <= 8'h00;
    end else if (tick) begin
      case (rx_st_r)
        RX_IDLE: begin
          if (rxs) begin
            armed_r <= 1'b1;
            if (idle_cnt_r != idle_lim) begin
              idle_cnt_r <= idle_cnt_r + 8'h01;
            end
            if (set_idle) begin
              got_char_r <= 1'b0;
            end
          end else if (armed_r) begin
            rx_st_r <= RX_FRAME;
            rt_r <= 4'h1;
            bit_r <= 4'h0;
            vlow_r <= 2'b00;
            nz_r <= 1'b0;
            idle_cnt_r <= 8'h00;
          end else begin
            idle_cnt_r <= 8'h00;
          end
        end
        RX_FRAME: begin
          rt_r <= rt_r + 4'h1;
          if ((bit_r == 4'h0) & ((rt_r == 4'h2) | (rt_r == 4'h4))) begin
            vlow_r <= vlow_r + {1'b0, ~rxs};
            nz_r <= nz_r | rxs;
          end
          if ((bit_r == 4'h0) & (rt_r == 4'h6)) begin
            nz_r <= nz_r | rxs;
            if ((vlow_r + {1'b0, ~rxs}) < 2'b10) begin
              rx_st_r <= RX_IDLE;
            end
          end
          if (rt_r == 4'h7) begin
            smp_r[1] <= rxs;
          end
          if (rt_r == 4'h8) begin
            smp_r[0] <= rxs;
          end
          if (rt_r == 4'h9) begin
            nz_r <= nz_r | odd;
            if (bit_r != 4'h0 && !last_bit) begin
              rsh_r <= rsh_in;
            end
            if (last_bit) begin
              // A plain framing error waits out its stop bit, so the artificial start
              // lands no earlier than the expected edge; a break needs a high line
              if (vote | is_break) begin
                rx_st_r <= RX_IDLE;
              end
              armed_r <= vote | ~is_break;
              if (accept & ~rx_buf_full_flag_r) begin
                rx_data_r <= is_break ? `BREAK_DATA : (len9 ? rsh_r[7:0] : rsh_r[8:1]);
                got_char_r <= 1'b1;
              end
            end
          end
          if (rt_r == 4'hf) begin
            bit_r <= bit_r + 4'h1;
            if (last_bit) begin
              rx_st_r <= RX_IDLE;
            end
          end
        end
        default: rx_st_r <= RX_IDLE;
      endcase
    end
  end

  // Transmitter
  reg [2:0] tx_st_r;
  reg [3:0] tx_rt_r;
  reg [10:0] tsh_r;
  reg [3:0] tcnt_r;
  reg te_d_r, pre_pend_r, brk_hi_r, busy_r;
  wire te = ctrl_two_r[`C2_TE];
  wire send_break_bit = ctrl_two_r[`C2_SBK];
  wire btick = tick & (tx_rt_r == `SAMPLES_PER_BIT - 1);
  wire tx_load_data = btick & (tcnt_r <= 4'h1) & te & tx_pend_r & ~send_break_bit & ~pre_pend_r & ~brk_hi_r;
  wire tx_end = btick & (tcnt_r <= 4'h1) & busy_r & ~send_break_bit & ~(te & (tx_pend_r | pre_pend_r))
                & ~brk_hi_r;
  always @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      tx_st_r <= TX_IDLE;
      tx_rt_r <= 4'h0;
      tsh_r <= 11'h7ff;
      tcnt_r <= 4'h0;
      te_d_r <= 1'b0;
      pre_pend_r <= 1'b0;
      brk_hi_r <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      te_d_r <= te;
      if (te & ~te_d_r) begin
        pre_pend_r <= 1'b1;
      end
      if (tick) begin
        tx_rt_r <= tx_rt_r + 4'h1;
      end
      if (btick) begin
        if (tcnt_r > 4'h1) begin
          tsh_r <= {1'b1, tsh_r[10:1]};
          tcnt_r <= tcnt_r - 4'h1;
        end else if (send_break_bit & (te | busy_r)) begin
          tx_st_r <= TX_BRK;
          tsh_r <= 11'h000;
          tcnt_r <= frame_bits;
          busy_r <= 1'b1;
          brk_hi_r <= 1'b1;
        end else if (brk_hi_r) begin
          tx_st_r <= TX_SEND;
          tsh_r <= 11'h7ff;
          tcnt_r <= 4'h1;
          brk_hi_r <= 1'b0;
        end else if (te & pre_pend_r) begin
          tx_st_r <= TX_SEND;
          tsh_r <= 11'h7ff;
          tcnt_r <= frame_bits;
          pre_pend_r <= 1'b0;
          busy_r <= 1'b1;
        end else if (tx_load_data) begin
          tx_st_r <= TX_SEND;
          tsh_r <= {1'b1, len9 ? ctrl_one_r[`C1_T8] : 1'b1, tx_buf_r, 1'b0};
          tcnt_r <= frame_bits;
          busy_r <= 1'b1;
        end else begin
          tx_st_r <= TX_IDLE;
          tsh_r <= 11'h7ff;
          tcnt_r <= 4'h0;
          busy_r <= 1'b0;
        end
      end
    end
  end
  assign o_tx_serial_out = busy_r ? tsh_r[0] : 1'b1;
  assign o_tx_drive = te | busy_r;

  // Registers and flags; hardware set wins over a clearing access
  wire tx_clr = wr_data;
  always @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      o_hrdata <= 32'h0;
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      rate_sel_r <= 5'h00;
      ctrl_one_r <= 4'h0;
      ctrl_two_r <= 8'h00;
      tx_buf_r <= 8'h00;
      tx_pend_r <= 1'b0;
      seen_r <= 7'h00;
      tx_buf_empty_flag_r <= 1'b1;
      tc_r <= 1'b1;
      rx_buf_full_flag_r <= 1'b0;
      idle_r <= 1'b0;
      or_r <= 1'b0;
      nf_r <= 1'b0;
      fe_r <= 1'b0;
    end else begin
      wr_pend_r <= addr_ok & i_hwrite;
      if (addr_ok & i_hwrite) begin
        wr_addr_r <= ra;
      end
      if (rd_go) begin
        o_hrdata <= rd_val;
      end
      if (rd_status) begin
        seen_r <= status_now[7:1];
      end else if (rd_data | wr_data) begin
        seen_r <= 7'h00;
      end
      if (wr_pend_r) begin
        if (wr_addr_r == `ADDR_RATE_SEL) begin
          rate_sel_r <= i_hwdata[4:0];
        end else if (wr_addr_r == `ADDR_CTRL_ONE) begin
          ctrl_one_r[3:1] <= i_hwdata[3:1];
        end else if (wr_addr_r == `ADDR_CTRL_TWO) begin
          ctrl_two_r <= i_hwdata[7:0];
        end else if (wr_addr_r == `ADDR_DATA) begin
          tx_buf_r <= i_hwdata[7:0];
        end
      end
      if (wake_idle | wake_addr) begin
        ctrl_two_r[`C2_RWU] <= 1'b0;
      end
      if (accept & ~rx_buf_full_flag_r & len9) begin
        ctrl_one_r[`C1_R8] <= rsh_r[8];
      end
      tx_pend_r <= tx_load_data ? 1'b0 : (wr_data ? 1'b1 : tx_pend_r);
      tx_buf_empty_flag_r <= tx_load_data | (tx_buf_empty_flag_r & ~(tx_clr & seen_r[`ST_TX_BUF_EMPTY_FLAG - 1]));
      tc_r <= tx_end | (tc_r & ~(tx_clr & seen_r[`ST_TC - 1]));
      rx_buf_full_flag_r <= set_rx_buf_full_flag | (rx_buf_full_flag_r & ~(rd_data & seen_r[`ST_RX_BUF_FULL_FLAG - 1]));
      idle_r <= set_idle | (idle_r & ~(rd_data & seen_r[`ST_IDLE - 1]));
      or_r <= set_or | (or_r & ~(rd_data & seen_r[`ST_OR - 1]));
      nf_r <= set_nf | (nf_r & ~(rd_data & seen_r[`ST_NF - 1]));
      fe_r <= set_fe | (fe_r & ~(rd_data & seen_r[`ST_FE - 1]));
    end
  end

  // Single request line; enables gate each flag except FE and NF, which never request
  assign o_irq = (tx_buf_empty_flag_r & ctrl_two_r[`C2_TIE]) | (tc_r & ctrl_two_r[`C2_TX_DONE_IRQ_EN])
               | ((rx_buf_full_flag_r | or_r) & ctrl_two_r[`C2_RIE] & ctrl_two_r[`C2_RE])
               | (idle_r & ctrl_two_r[`C2_ILIE]);
endmodule

// ==== dv/async_serial_props.sv ====
// Purpose: Port checks for the async serial interface
// Assumes: One clock, asynchronous active-high reset
// Notes: Bound to the top module below
`timescale 1ns/1ps
module async_serial_props (
  input wire i_clock,
  input wire i_reset,
  input wire i_hsel,
  input wire [31:0] i_haddr,
  input wire [1:0] i_htrans,
  input wire i_hwrite,
  input wire i_hready,
  input wire [31:0] o_hrdata,
  input wire o_hreadyout,
  input wire o_hresp,
  input wire o_tx_serial_out,
  input wire o_tx_drive,
  input wire o_irq
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_reset);
  wire rd_take = i_hsel && i_htrans[1] && i_hready && !i_hwrite;
  property p_zero_wait; o_hreadyout && !o_hresp; endproperty
  a_zero_wait: assert property (p_zero_wait) else $error("bus not ready or not okay");
  property p_idle_high; !o_tx_drive |-> o_tx_serial_out; endproperty
  a_idle_high: assert property (p_idle_high) else $error("released line low");
  property p_start_owned; $fell(o_tx_serial_out) |-> o_tx_drive; endproperty
  a_start_owned: assert property (p_start_owned) else $error("start while released");
  // Fastest rate gives sixteen clocks per bit, so a low start lasts at least eight
  property p_start_len; $fell(o_tx_serial_out) |-> !o_tx_serial_out [*8]; endproperty
  a_start_len: assert property (p_start_len) else $error("start bit too short");
  property p_release_high; $fell(o_tx_drive) |-> o_tx_serial_out; endproperty
  a_release_high: assert property (p_release_high) else $error("released mid bit");
  property p_irq_reset; $fell(i_reset) |-> !o_irq; endproperty
  a_irq_reset: assert property (p_irq_reset) else $error("irq out of reset");
  property p_rdata_holds; !rd_take |=> $stable(o_hrdata); endproperty
  a_rdata_holds: assert property (p_rdata_holds) else $error("read data moved");
  property p_unmapped; rd_take && i_haddr[7:0] == 8'h20 |=> o_hrdata == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_status_shape;
    rd_take && i_haddr[7:0] == 8'h0c |=> o_hrdata[31:8] == 24'h0 && !o_hrdata[0];
  endproperty
  a_status_shape: assert property (p_status_shape) else $error("status spare bits set");
  c_tx_start: cover property ($fell(o_tx_serial_out));
  c_irq: cover property ($rose(o_irq));
  c_release: cover property ($fell(o_tx_drive));
endmodule
bind async_serial_interface async_serial_props async_serial_props_i (.*);

// ==== dv/remote_station.sv ====
// Purpose: Remote serial station on the far side of the link
// Assumes: Fixed bit time in clocks, idle-high pulled-up lines
// Notes: Sends whole frames; receives by mid-bit sampling
`timescale 1ns/1ps
module remote_station #(parameter int BIT_CLKS = 16) (
  input wire logic i_clock,
  input wire logic i_line,
  output logic o_line
);
  initial o_line = 1'b1;
  // A low stop with zero data makes ten low bits, which is a break
  task automatic send(input logic [7:0] d, input logic glitch, input logic stop);
    logic [9:0] f;
    f = {stop, d, 1'b0};
    for (int b = 0; b < 10; b++) begin
      for (int c = 0; c < BIT_CLKS; c++) begin
        @(posedge i_clock);
        o_line <= (glitch && b == 4 && (c == 9 || c == 10)) ? ~f[b] : f[b];
      end
    end
    @(posedge i_clock);
    o_line <= 1'b1;
  endtask
  task automatic recv(output logic [7:0] d, output logic stop, output int w);
    w = 0;
    while (i_line !== 1'b0 && w < 4000) begin
      @(posedge i_clock);
      w++;
    end
    repeat (BIT_CLKS / 2) @(posedge i_clock);
    for (int b = 0; b < 8; b++) begin
      repeat (BIT_CLKS) @(posedge i_clock);
      d[b] = i_line;
    end
    repeat (BIT_CLKS) @(posedge i_clock);
    stop = i_line;
  endtask
endmodule

// ==== dv/async_serial_interface_tb.sv ====
// Purpose: Self-checking bench for the async serial interface
// Assumes: Rate select 0, sixteen clocks per bit
// Notes: Remote station drives the receive line
`timescale 1ns/1ps
`include "async_serial_consts.vh"
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end
module async_serial_interface_tb;
  logic i_clock = 1'b0;
  logic i_reset = 1'b1;
  logic i_hsel = 1'b0;
  logic [31:0] i_haddr = 32'h0;
  logic [1:0] i_htrans = 2'b00;
  logic i_hwrite = 1'b0;
  logic [31:0] i_hwdata = 32'h0;
  wire [31:0] o_hrdata;
  wire o_hreadyout, o_hresp, o_tx_serial_out, o_tx_drive, o_irq, rx_line;
  wire i_hready = o_hreadyout;
  // Released transmit line floats to its pull-up level
  wire tx_wire = o_tx_drive ? o_tx_serial_out : 1'b1;
  int n_errors = 0;
  int comparisons = 0;
  int wt;
  logic [31:0] rdv;
  logic [7:0] rxd;
  logic stp;
  async_serial_interface async_serial_interface_i (.i_clock(i_clock), .i_reset(i_reset),
    .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
    .i_hsize(3'b010), .i_hwdata(i_hwdata), .i_hready(i_hready), .o_hrdata(o_hrdata),
    .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .i_rx_serial_in(rx_line),
    .o_tx_serial_out(o_tx_serial_out), .o_tx_drive(o_tx_drive), .o_irq(o_irq));
  remote_station remote_station_i (.i_clock(i_clock), .i_line(tx_wire), .o_line(rx_line));
  task automatic final_report;
    $display("Mismatches %0d of %0d comparisons", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge i_clock);
      n++;
    end while (o_hreadyout !== 1'b1 && n < 50);
    if (o_hreadyout !== 1'b1) begin
      n_errors++;
      final_report();
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge i_clock);
    i_hsel <= 1'b1;
    i_htrans <= 2'b10;
    i_hwrite <= wr;
    i_haddr <= {24'h0, a};
    wait_ready();
    i_htrans <= 2'b00;
    i_hsel <= 1'b0;
    i_hwdata <= wd;
    wait_ready();
    rdv = o_hrdata;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                        input string nm);
    bus(1'b0, a, 32'h0);
    `CHK(nm, e & m, rdv & m)
  endtask
  task automatic tx_char(input logic [7:0] d, input logic stop_te);
    fork
      remote_station_i.recv(rxd, stp, wt);
      begin
        bus(1'b1, `ADDR_DATA, {24'h0, d});
        repeat (40) @(posedge i_clock);
        if (stop_te) bus(1'b1, `ADDR_CTRL_TWO, 32'h04);
      end
    join
    if (wt >= 4000) begin
      n_errors++;
      final_report();
    end
    repeat (20) @(posedge i_clock);
  endtask
  initial begin
    forever #10 i_clock = ~i_clock;
  end
  initial begin
    repeat (3) @(posedge i_clock);
    i_reset <= 1'b0;
    rd_chk(`ADDR_STATUS, 32'hff, 32'hc0, "reset status");
    rd_chk(8'h20, 32'hffffffff, 32'h0, "unmapped");
    bus(1'b1, `ADDR_RATE_SEL, 32'h0);
    bus(1'b1, `ADDR_CTRL_TWO, 32'h40);
    @(negedge i_clock);
    `CHK("irq on", 1'b1, o_irq)
    bus(1'b1, `ADDR_CTRL_TWO, 32'h0c);
    @(negedge i_clock);
    `CHK("irq off", 1'b0, o_irq)
    tx_char(8'ha5, 1'b0);
    `CHK("tx data", 8'ha5, rxd)
    `CHK("tx stop", 1'b1, stp)
    `CHK("preamble", 1'b1, wt >= 150)
    rd_chk(`ADDR_STATUS, 32'hd0, 32'hc0, "tx status");
    remote_station_i.send(8'h3c, 1'b0, 1'b1);
    rd_chk(`ADDR_STATUS, 32'h3e, 32'h20, "rx status");
    rd_chk(`ADDR_DATA, 32'hff, 32'h3c, "rx data");
    repeat (200) @(posedge i_clock);
    rd_chk(`ADDR_STATUS, 32'h3e, 32'h10, "idle");
    bus(1'b0, `ADDR_DATA, 32'h0);
    rd_chk(`ADDR_STATUS, 32'h3e, 32'h0, "cleared");
    remote_station_i.send(8'h55, 1'b1, 1'b1);
    rd_chk(`ADDR_STATUS, 32'h04, 32'h04, "noise");
    bus(1'b0, `ADDR_DATA, 32'h0);
    remote_station_i.send(8'h00, 1'b0, 1'b0);
    repeat (20) @(posedge i_clock);
    rd_chk(`ADDR_STATUS, 32'h2e, 32'h22, "break");
    rd_chk(`ADDR_DATA, 32'hff, 32'h0, "break data");
    remote_station_i.send(8'h11, 1'b0, 1'b1);
    remote_station_i.send(8'h22, 1'b0, 1'b1);
    rd_chk(`ADDR_STATUS, 32'h2e, 32'h28, "overrun");
    rd_chk(`ADDR_DATA, 32'hff, 32'h11, "kept data");
    remote_station_i.send(8'h55, 1'b0, 1'b0);
    remote_station_i.send(8'h66, 1'b0, 1'b1);
    rd_chk(`ADDR_STATUS, 32'h2e, 32'h2a, "frame err");
    rd_chk(`ADDR_DATA, 32'hff, 32'h55, "frame err data");
    bus(1'b1, `ADDR_CTRL_ONE, 32'h08);
    bus(1'b1, `ADDR_CTRL_TWO, 32'h0e);
    remote_station_i.send(8'h12, 1'b0, 1'b1);
    rd_chk(`ADDR_STATUS, 32'h3e, 32'h0, "standby");
    remote_station_i.send(8'h92, 1'b0, 1'b1);
    rd_chk(`ADDR_CTRL_TWO, 32'h02, 32'h0, "woken");
    rd_chk(`ADDR_STATUS, 32'h20, 32'h20, "addr full");
    rd_chk(`ADDR_DATA, 32'hff, 32'h92, "addr data");
    bus(1'b1, `ADDR_CTRL_ONE, 32'h0);
    bus(1'b1, `ADDR_CTRL_TWO, 32'h0e);
    repeat (100) @(posedge i_clock);
    rd_chk(`ADDR_CTRL_TWO, 32'h02, 32'h02, "asleep");
    repeat (200) @(posedge i_clock);
    rd_chk(`ADDR_CTRL_TWO, 32'h02, 32'h0, "idle wake");
    rd_chk(`ADDR_STATUS, 32'hff, 32'hc0, "snapshot");
    fork
      remote_station_i.recv(rxd, stp, wt);
      bus(1'b1, `ADDR_CTRL_TWO, 32'h0d);
    join
    `CHK("break tx seen", 1'b1, wt < 4000)
    `CHK("break tx data", 8'h00, rxd)
    `CHK("break tx stop", 1'b0, stp)
    bus(1'b1, `ADDR_CTRL_TWO, 32'h0c);
    repeat (20) @(posedge i_clock);
    `CHK("break end", 1'b1, o_tx_serial_out)
    tx_char(8'h5a, 1'b1);
    `CHK("tail data", 8'h5a, rxd)
    rd_chk(`ADDR_STATUS, 32'hc0, 32'hc0, "done off");
    final_report();
  end
endmodule
